//--- core/emw_adapter.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Top strobe pin is extra low address; two lower strobes are byte enables.
// - Byte size shifts internal address right by two.
// - Internal bit 23 fills vacated upper pins when shifting.
// - Byte size drives internal bit 1 on the extra low bit.
// - Byte size: bit 0 low enables lane 0, high enables lane 1.
// - Bytes move on lines 7-0 or 15-8 per enabled lane.
// - Half-word size shifts right by one, bit 0 on extra bit.
// - Half-word size enables both lanes, data on lines 15-0.
// - Word size keeps the address unshifted.
// - Word size makes two accesses, extra bit 0 then 1.
// - Word access lasts one extra access cycle.
// - Reads and writes use identical mapping.
module emw_adapter
  import emw_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire emw_req_t req,
  output logic req_ready,
  output logic [23:0] mem_addr,
  output logic lane3_strobe_or_half_select_n,
  output logic lane1_byte_enable_n,
  output logic lane0_byte_enable_n,
  output logic mem_cs_n,
  output logic mem_we_n,
  output logic [15:0] mem_dout,
  output logic [15:0] mem_doe,
  input wire logic [15:0] mem_din,
  output logic [31:0] rdata,
  output logic done
);

  // ******************************
  // State
  // ******************************
  typedef struct packed {
    emw_state_t state;
    emw_req_t cur;
    emw_pins_t pins;
    logic ready;
    logic [31:0] rdata;
    logic done;
  } emw_st_t;

  emw_st_t st_reg;
  emw_st_t st_next;
  logic [23:0] map_addr;
  logic map_half;
  logic [1:0] map_be_n;
  emw_req_t use_req;
  logic use_second;
  logic [15:0] lane_word;
  logic [15:0] rd_word;

  emw_map u_map (
    .size(use_req.size),
    .addr(use_req.addr),
    .second_half(use_second),
    .ext_addr(map_addr),
    .half_select(map_half),
    .be_n(map_be_n)
  );

  // ******************************
  // Next state
  // ******************************
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    use_second = (st_reg.state == EMW_XFER) &&
                 (st_reg.cur.size == EMW_SIZE_32);
    use_req = use_second ? st_reg.cur : req;
    // Byte writes replicate onto both lanes; the enable picks one
    lane_word = (use_req.size == EMW_SIZE_8) ?
                {2{use_req.wdata[7:0]}} : use_req.wdata[15:0];
    if (use_second) begin
      lane_word = st_reg.cur.wdata[31:16];
    end
    // Read byte sits in low bits whichever lane carried it
    rd_word = mem_din;
    if (st_reg.cur.size == EMW_SIZE_8) begin
      rd_word = {8'h00, st_reg.pins.be_n[0] ?
                 mem_din[15:8] : mem_din[7:0]};
    end
    case (st_reg.state)
      EMW_IDLE: begin
        st_next.pins.be_n = EMW_BE_IDLE_N;
        st_next.pins.cs_n = 1'b1;
        st_next.pins.we_n = 1'b1;
        st_next.pins.doe = EMW_DATA_RST;
        st_next.ready = 1'b1;
        if (req.valid && req.size != EMW_SIZE_RSV) begin
          st_next.cur = req;
          st_next.state = EMW_XFER;
          st_next.ready = 1'b0;
          st_next.pins.addr = map_addr;
          st_next.pins.half_select = map_half;
          st_next.pins.be_n = map_be_n;
          st_next.pins.cs_n = 1'b0;
          st_next.pins.we_n = ~req.write;
          st_next.pins.dout = lane_word;
          st_next.pins.doe = {16{req.write}};
        end
      end
      EMW_XFER: begin
        if (st_reg.cur.size == EMW_SIZE_32) begin
          st_next.rdata[15:0] = mem_din;
          st_next.state = EMW_HALF1;
          st_next.pins.addr = map_addr;
          st_next.pins.half_select = map_half;
          st_next.pins.be_n = map_be_n;
          st_next.pins.dout = lane_word;
        end else begin
          st_next.rdata = {16'h0000, rd_word};
          st_next.done = 1'b1;
          st_next.state = EMW_IDLE;
          st_next.ready = 1'b1;
          st_next.pins.be_n = EMW_BE_IDLE_N;
          st_next.pins.cs_n = 1'b1;
          st_next.pins.we_n = 1'b1;
          st_next.pins.doe = EMW_DATA_RST;
        end
      end
      EMW_HALF1: begin
        st_next.rdata[31:16] = mem_din;
        st_next.done = 1'b1;
        st_next.state = EMW_IDLE;
        st_next.ready = 1'b1;
        st_next.pins.be_n = EMW_BE_IDLE_N;
        st_next.pins.cs_n = 1'b1;
        st_next.pins.we_n = 1'b1;
        st_next.pins.doe = EMW_DATA_RST;
      end
      default: begin
        st_next.state = EMW_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
      st_reg.state <= EMW_IDLE;
      st_reg.pins.be_n <= EMW_BE_IDLE_N;
      st_reg.pins.cs_n <= 1'b1;
      st_reg.pins.we_n <= 1'b1;
      st_reg.ready <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ******************************
  // Outputs
  // ******************************
  assign req_ready = st_reg.ready;
  assign mem_addr = st_reg.pins.addr;
  assign lane3_strobe_or_half_select_n = st_reg.pins.half_select;
  assign lane1_byte_enable_n = st_reg.pins.be_n[1];
  assign lane0_byte_enable_n = st_reg.pins.be_n[0];
  assign mem_cs_n = st_reg.pins.cs_n;
  assign mem_we_n = st_reg.pins.we_n;
  assign mem_dout = st_reg.pins.dout;
  assign mem_doe = st_reg.pins.doe;
  assign rdata = st_reg.rdata;
  assign done = st_reg.done;

  // ******************************
  // Checks
  // ******************************
  sequence s_word_start;
    st_reg.state == EMW_IDLE && req.valid && req.size == EMW_SIZE_32;
  endsequence

  a_word_halves: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    s_word_start |=> !st_reg.pins.half_select ##1 st_reg.pins.half_select)
    else $error("word halves out of order");

  a_word_length: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    s_word_start |=> !done ##1 !done ##1 done)
    else $error("word access length wrong");

  a_byte_lane: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    st_reg.state == EMW_IDLE && req.valid && req.size == EMW_SIZE_8
    |=> (lane0_byte_enable_n ^ lane1_byte_enable_n) &&
        lane1_byte_enable_n == !$past(req.addr[0]))
    else $error("byte lane enable wrong");

  a_byte_shift: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    st_reg.state == EMW_IDLE && req.valid && req.size == EMW_SIZE_8
    |=> mem_addr[23:21] == {3{$past(req.addr[23])}} &&
        mem_addr[20:0] == $past(req.addr[22:2]) &&
        lane3_strobe_or_half_select_n == $past(req.addr[1]))
    else $error("byte address mapping wrong");

  a_half_map: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    st_reg.state == EMW_IDLE && req.valid && req.size == EMW_SIZE_16
    |=> mem_addr == {$past(req.addr[23]), $past(req.addr[23:1])} &&
        lane3_strobe_or_half_select_n == $past(req.addr[0]) &&
        !lane0_byte_enable_n && !lane1_byte_enable_n)
    else $error("half-word mapping wrong");

  // Second half compares with the address taken, not the live request
  a_word_addr: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    s_word_start |=> mem_addr == $past(req.addr) ##1
                     mem_addr == $past(req.addr, 2))
    else $error("word address shifted");

  a_word_rdata: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    s_word_start ##1 1'b1 ##1 1'b1 |=> rdata == {$past(mem_din),
                                                 $past(mem_din, 2)})
    else $error("word halves packed wrong");

  a_dir_match: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    !mem_cs_n |-> (mem_we_n == (mem_doe == 16'h0000)))
    else $error("direction and drive disagree");

endmodule : emw_adapter

//--- core/emw_map.sv
`timescale 1ns/10ps
module emw_map
  import emw_pkg::*;
(
  input wire emw_size_t size,
  input wire logic [23:0] addr,
  input wire logic second_half,
  output logic [23:0] ext_addr,
  output logic half_select,
  output logic [1:0] be_n
);

  // ******************************
  // Address and strobe mapping
  // ******************************
  always_comb begin
    ext_addr = addr;
    half_select = 1'b0;
    be_n = EMW_BE_BOTH_N;
    case (size)
      EMW_SIZE_8: begin
        ext_addr = {{2{addr[EMW_TOP_BIT]}}, addr[23:2]};
        half_select = addr[1];
        be_n = addr[0] ? EMW_BE_LANE1_N : EMW_BE_LANE0_N;
      end
      EMW_SIZE_16: begin
        ext_addr = {addr[EMW_TOP_BIT], addr[23:1]};
        half_select = addr[0];
        be_n = EMW_BE_BOTH_N;
      end
      default: begin
        ext_addr = addr;
        half_select = second_half;
        be_n = EMW_BE_BOTH_N;
      end
    endcase
  end

endmodule : emw_map

//--- core/emw_pkg.sv
package emw_pkg;

  // ******************************
  // Widths
  // ******************************
  localparam int EMW_ADDR_W = 24;
  localparam int EMW_DATA_W = 16;
  localparam int EMW_WORD_W = 32;
  localparam int EMW_TOP_BIT = 23;

  // ******************************
  // Reset values and strobe enable codes
  // ******************************
  localparam logic [23:0] EMW_ADDR_RST = 24'h00_0000;
  localparam logic [15:0] EMW_DATA_RST = 16'h0000;
  localparam logic [31:0] EMW_WORD_RST = 32'h0000_0000;
  localparam logic [1:0] EMW_BE_IDLE_N = 2'h3;
  localparam logic [1:0] EMW_BE_BOTH_N = 2'h0;
  localparam logic [1:0] EMW_BE_LANE0_N = 2'h2;
  localparam logic [1:0] EMW_BE_LANE1_N = 2'h1;

  // ******************************
  // Types
  // ******************************
  typedef enum logic [1:0] {
    EMW_SIZE_8,
    EMW_SIZE_16,
    EMW_SIZE_32,
    EMW_SIZE_RSV
  } emw_size_t;

  typedef enum {
    EMW_IDLE,
    EMW_XFER,
    EMW_HALF1
  } emw_state_t;

  // Request from core
  typedef struct packed {
    logic valid;
    logic write;
    emw_size_t size;
    logic [23:0] addr;
    logic [31:0] wdata;
  } emw_req_t;

  // External memory pins
  typedef struct packed {
    logic [23:0] addr;
    logic half_select;
    logic [1:0] be_n;
    logic cs_n;
    logic we_n;
    logic [15:0] dout;
    logic [15:0] doe;
  } emw_pins_t;

endpackage : emw_pkg

//--- tb/emw_sram_model.sv
`timescale 1ns/10ps
module emw_sram_model
  import emw_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [23:0] mem_addr,
  input wire logic half_select,
  input wire logic lane1_byte_enable_n,
  input wire logic lane0_byte_enable_n,
  input wire logic mem_cs_n,
  input wire logic mem_we_n,
  input wire logic [15:0] mem_dout,
  input wire logic [15:0] mem_doe,
  output logic [15:0] mem_din
);
  logic [15:0] mem [logic [23:0]];
  logic [15:0] last_reg = 16'h0000;
  logic [23:0] key;
  assign key = {mem_addr[22:0], half_select};
  // Idle bus shows inverted data so stale reads never match
  always @* begin
    if (!mem_cs_n && mem_we_n)
      mem_din = mem.exists(key) ? mem[key] : 16'h0000;
    else
      mem_din = ~last_reg;
  end
  // Undriven data bits are stored corrupted
  always @(posedge ref_clk) begin
    if (!mem_cs_n && mem_we_n)
      last_reg <= mem_din;
    if (!mem_cs_n && !mem_we_n) begin
      if (!mem.exists(key))
        mem[key] = 16'h0000;
      if (!lane0_byte_enable_n)
        mem[key][7:0] = mem_dout[7:0] ^ ~mem_doe[7:0];
      if (!lane1_byte_enable_n)
        mem[key][15:8] = mem_dout[15:8] ^ ~mem_doe[15:8];
    end
  end
endmodule : emw_sram_model

//--- tb/tb.sv
`timescale 1ns/10ps
module tb
  import emw_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  emw_req_t req;
  logic req_ready, half_n, be1_n, be0_n, mem_cs_n, mem_we_n, done;
  logic [23:0] mem_addr;
  logic [15:0] mem_dout, mem_doe, mem_din;
  logic [31:0] rdata, rd;
  logic [29:0] pv;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  assign pv = {done, mem_addr, half_n, be1_n, be0_n, mem_cs_n, mem_we_n};

  always #5 ref_clk = ~ref_clk;

  emw_adapter emw_adapter_i (.ref_clk(ref_clk), .rst_b(rst_b), .req(req),
    .req_ready(req_ready), .mem_addr(mem_addr),
    .lane3_strobe_or_half_select_n(half_n), .lane1_byte_enable_n(be1_n),
    .lane0_byte_enable_n(be0_n), .mem_cs_n(mem_cs_n), .mem_we_n(mem_we_n),
    .mem_dout(mem_dout), .mem_doe(mem_doe), .mem_din(mem_din),
    .rdata(rdata), .done(done));

  emw_sram_model emw_sram_model_i (.ref_clk(ref_clk), .mem_addr(mem_addr),
    .half_select(half_n), .lane1_byte_enable_n(be1_n),
    .lane0_byte_enable_n(be0_n), .mem_cs_n(mem_cs_n), .mem_we_n(mem_we_n),
    .mem_dout(mem_dout), .mem_doe(mem_doe), .mem_din(mem_din));

  // ********************
  // Helpers
  // ********************
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  function logic [29:0] pins(emw_size_t sz, logic [23:0] a, logic h,
                             logic w);
    logic [23:0] ea;
    logic hs;
    logic [1:0] be;
    ea = a;
    hs = h;
    be = 2'h0;
    if (sz == EMW_SIZE_8) begin
      ea = {{3{a[23]}}, a[22:2]};
      hs = a[1];
      be = a[0] ? 2'h1 : 2'h2;
    end
    if (sz == EMW_SIZE_16) begin
      ea = {a[23], a[23:1]};
      hs = a[0];
    end
    return {1'b0, ea, hs, be, 1'b0, ~w};
  endfunction : pins

  task acc(input logic w, input emw_size_t sz, input logic [23:0] a,
           input logic [31:0] wd);
    @(posedge ref_clk);
    req <= '{1'b1, w, sz, a, wd};
    @(posedge ref_clk);
    req.valid <= 1'b0;
    #1;
    chk({2'h0, pv}, {2'h0, pins(sz, a, 1'b0, w)});
    chk({15'h0, req_ready, mem_doe}, {16'h0, {16{w}}});
    if (w)
      chk({16'h0, mem_dout}, sz == EMW_SIZE_8 ? {16'h0, {2{wd[7:0]}}}
                                              : {16'h0, wd[15:0]});
    if (sz == EMW_SIZE_32) begin
      @(posedge ref_clk);
      #1;
      chk({2'h0, pv}, {2'h0, pins(sz, a, 1'b1, w)});
      if (w)
        chk({16'h0, mem_dout}, {16'h0, wd[31:16]});
    end
    @(posedge ref_clk);
    #1;
    chk({29'h0, mem_cs_n, req_ready, done}, 32'h0000_0007);
    rd = rdata;
  endtask : acc

  // ********************
  // Scenarios
  // ********************
  task t_bytes;
    for (int i = 0; i < 4; i++)
      acc(1'b1, EMW_SIZE_8, 24'h00_4000 + 24'(i),
          32'h0000_0011 * 32'(i + 1));
    acc(1'b0, EMW_SIZE_16, 24'h00_2000, 32'h0000_0000);
    chk(rd, 32'h0000_2211);
    acc(1'b0, EMW_SIZE_16, 24'h00_2001, 32'h0000_0000);
    chk(rd, 32'h0000_4433);
    acc(1'b0, EMW_SIZE_32, 24'h00_1000, 32'h0000_0000);
    chk(rd, 32'h4433_2211);
    acc(1'b0, EMW_SIZE_8, 24'h00_4003, 32'h0000_0000);
    chk(rd, 32'h0000_0044);
    acc(1'b0, EMW_SIZE_8, 24'h00_4000, 32'h0000_0000);
    chk(rd, 32'h0000_0011);
  endtask : t_bytes

  task t_high;
    acc(1'b1, EMW_SIZE_32, 24'h90_4002, 32'hcafe_1234);
    acc(1'b0, EMW_SIZE_32, 24'h90_4002, 32'h0000_0000);
    chk(rd, 32'hcafe_1234);
    acc(1'b1, EMW_SIZE_16, 24'h80_0005, 32'h0000_5a5a);
    acc(1'b0, EMW_SIZE_16, 24'h80_0005, 32'h0000_0000);
    chk(rd, 32'h0000_5a5a);
    acc(1'b1, EMW_SIZE_8, 24'h90_4001, 32'h0000_0077);
    acc(1'b0, EMW_SIZE_8, 24'h90_4001, 32'h0000_0000);
    chk(rd, 32'h0000_0077);
  endtask : t_high

  // Unused size code must start no access at all
  task t_reserved;
    @(posedge ref_clk);
    req <= '{1'b1, 1'b1, EMW_SIZE_RSV, 24'h00_4000, 32'h0000_0000};
    repeat (2) @(posedge ref_clk);
    req.valid <= 1'b0;
    #1;
    chk({29'h0, mem_cs_n, req_ready, done}, 32'h0000_0006);
  endtask : t_reserved

  initial begin
    req = '0;
    repeat (3) @(posedge ref_clk);
    #1;
    chk({12'h0, req_ready, be1_n, be0_n, mem_cs_n, mem_doe},
        32'h0007_0000);
    @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge ref_clk);
    t_bytes();
    t_high();
    t_reserved();
    report_and_stop();
  end
endmodule : tb
